// ### common/std_timer_pkg.sv
// Package for the standard timer core: register map, field positions, codes.
// Assumes a 32-bit AHB-Lite register bus with one aligned word per register.
package std_timer_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_CTRL0   = 8'h00;
  localparam logic [7:0] OFF_CTRL1   = 8'h04;
  localparam logic [7:0] OFF_CNT_LO  = 8'h08;
  localparam logic [7:0] OFF_CNT_HI  = 8'h0c;
  localparam logic [7:0] OFF_CMPA_LO = 8'h10;
  localparam logic [7:0] OFF_CMPA_HI = 8'h14;
  localparam logic [7:0] OFF_STATUS  = 8'h18;

  // Reset values.
  localparam logic [7:0] CTRL0_RST = 8'h00;
  localparam logic [7:0] CTRL1_RST = 8'h00;
  localparam logic [9:0] CMPA_RST  = 10'h000;

  // Field positions.
  localparam int CTRL0_PAUSE = 7;
  localparam int CTRL0_ON    = 3;
  localparam int CTRL1_OC    = 3;
  localparam int CTRL1_POL   = 2;
  localparam int CTRL1_DPX   = 1;
  localparam int CTRL1_CCLR  = 0;

  // Status bits: flag A and flag P, cleared by writing one.
  localparam int STAT_AF = 0;
  localparam int STAT_PF = 1;

  // Prescaler ratios and counter width.
  localparam int DIV_SYS4   = 4;
  localparam int DIV_HI16   = 16;
  localparam int DIV_HI64   = 64;
  localparam int CNT_WIDTH  = 10;

  typedef enum logic [1:0] {
    MODE_CMP, MODE_CAP, MODE_PWM, MODE_TMR
  } mode_e;

  typedef enum logic [2:0] {
    CK_SYS4, CK_SYS, CK_HI16, CK_HI64, CK_TBC, CK_STOP, CK_EXT_R, CK_EXT_F
  } clk_sel_e;

  // Control register 0 layout.
  typedef struct packed {
    logic       pause;
    clk_sel_e   clk_sel;
    logic       on;
    logic [2:0] cmp_p;
  } ctrl0_s;

  // Control register 1 layout.
  typedef struct packed {
    mode_e      mode;
    logic [1:0] pin_fn;
    logic       init_lvl;
    logic       invert;
    logic       swap;
    logic       clr_sel;
  } ctrl1_s;

endpackage : std_timer_pkg

// ### tb/std_timer_core_test.sv
// Self-checking bench for the timer core over AHB-Lite.
// Assumes a zero-wait slave; waits stay bounded all the same.
`timescale 1ns/1ps
`default_nettype none
module std_timer_core_test;
  import std_timer_pkg::*;
  logic        core_clk_i, srst_i, hsel, hwrite, hs_tick, tb_tick;
  logic        hreadyout, hresp, ext_cnt, cap, pin0, pin1, af, pf;
  logic [7:0]  haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, r;
  logic [9:0]  c;
  int          err_count, n_checks;

  std_timer_core u_std_timer_core (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .high_speed_tick_i(hs_tick),
    .timebase_tick_i(tb_tick), .ext_count_input_i(ext_cnt), .capture_pin_i(cap),
    .timer_output_zero_o(pin0), .timer_output_one_o(pin1),
    .compare_a_flag_o(af), .compare_p_flag_o(pf));
  std_timer_pins u_std_timer_pins (.clk_i(core_clk_i), .ext_count_o(ext_cnt),
    .capture_o(cap));

  // Clock at 50 MHz.
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end

  // Internal tick enables run free so the prescaled sources see traffic.
  always @(posedge core_clk_i) begin
    hs_tick <= ~hs_tick;
    tb_tick <= hs_tick & ~tb_tick;
  end

  task automatic final_report;
    $display("errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic fail(input string m);
    err_count++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  task automatic chk32(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e) fail(m);
  endtask

  task automatic chk1(input logic g, input logic e, input string m);
    n_checks++;
    if (g !== e) fail(m);
  endtask

  // Steps one edge, then on until hready is sampled high at an edge.
  task automatic wait_rdy;
    int i;
    i = 0;
    @(posedge core_clk_i);
    while (hreadyout !== 1'b1) begin
      i++;
      if (i > 50) begin
        fail("bus hang");
        final_report;
      end
      @(posedge core_clk_i);
    end
  endtask

  // One single word transfer; read data is taken at the data phase's last edge.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize  <= 3'b010;
    wait_rdy;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy;
    r = hrdata;
  endtask

  task automatic rd_cnt;
    logic [31:0] lo;
    bus(OFF_CNT_LO, 1'b0, 32'h0);
    lo = r;
    bus(OFF_CNT_HI, 1'b0, 32'h0);
    c = {r[1:0], lo[7:0]};
  endtask

  // The timer is switched off before its mode changes, then flags are cleared.
  task automatic cfg(input ctrl0_s c0, input ctrl1_s c1);
    bus(OFF_CTRL0, 1'b1, 32'h0);
    bus(OFF_CTRL1, 1'b1, {24'h0, c1});
    bus(OFF_STATUS, 1'b1, 32'h3);
    bus(OFF_CTRL0, 1'b1, {24'h0, c0});
  endtask

  task automatic t_reset;
    for (int a = 0; a < 32; a += 4) begin
      bus(8'(a), 1'b0, 32'h0);
      chk32(r, 32'h0, "reset or unmapped value");
    end
    bus(OFF_CNT_LO, 1'b1, 32'hff);
    rd_cnt;
    chk32({22'h0, c}, 32'h0, "count took a write");
    bus(OFF_CMPA_LO, 1'b1, 32'ha5);
    bus(OFF_CMPA_HI, 1'b1, 32'hff);
    bus(OFF_CMPA_LO, 1'b0, 32'h0);
    chk32(r, 32'ha5, "compare low");
    bus(OFF_CMPA_HI, 1'b0, 32'h0);
    chk32(r, 32'h3, "compare high");
  endtask

  task automatic t_ext;
    clk_sel_e cs;
    for (int k = 0; k < 2; k++) begin
      cs = k ? CK_EXT_F : CK_EXT_R;
      cfg(ctrl0_s'{1'b0, cs, 1'b1, 3'b000}, ctrl1_s'{MODE_TMR, 2'b00, 1'b0, 1'b0, 1'b0, 1'b0});
      u_std_timer_pins.pulse(4);
      rd_cnt;
      chk32({22'h0, c}, 32'h4, "edge count");
      bus(OFF_CTRL0, 1'b1, {24'h0, ctrl0_s'{1'b1, cs, 1'b1, 3'b000}});
      u_std_timer_pins.pulse(3);
      rd_cnt;
      chk32({22'h0, c}, 32'h4, "count moved in pause");
      bus(OFF_CTRL0, 1'b1, {24'h0, ctrl0_s'{1'b0, cs, 1'b1, 3'b000}});
      u_std_timer_pins.pulse(2);
      rd_cnt;
      chk32({22'h0, c}, 32'h6, "resume count");
      bus(OFF_CTRL0, 1'b1, {24'h0, ctrl0_s'{1'b0, cs, 1'b0, 3'b000}});
      u_std_timer_pins.pulse(2);
      rd_cnt;
      chk32({22'h0, c}, 32'h6, "count moved while off");
      bus(OFF_CTRL0, 1'b1, {24'h0, ctrl0_s'{1'b0, cs, 1'b1, 3'b000}});
      // The clear on a rising on bit lands one edge after the write.
      @(posedge core_clk_i);
      rd_cnt;
      chk32({22'h0, c}, 32'h0, "switch-on clear");
    end
    cfg(ctrl0_s'{1'b0, CK_STOP, 1'b1, 3'b000}, ctrl1_s'{MODE_TMR, 2'b00, 1'b0, 1'b0, 1'b0, 1'b0});
    repeat (40) @(posedge core_clk_i);
    rd_cnt;
    chk32({22'h0, c}, 32'h0, "stopped source counted");
  endtask

  // Every pin action on an A match at 3, with the pin level worked out from init and invert.
  task automatic t_cmp;
    logic [1:0] fn;
    logic       ini, inv, e;
    bus(OFF_CMPA_LO, 1'b1, 32'h3);
    bus(OFF_CMPA_HI, 1'b1, 32'h0);
    for (int k = 0; k < 4; k++) begin
      fn  = 2'(k);
      ini = (k < 2);
      inv = (k == 3);
      e   = (k == 0) ? ini : (k == 1) ? 1'b0 : (k == 2) ? 1'b1 : ~ini;
      cfg(ctrl0_s'{1'b0, CK_EXT_R, 1'b1, 3'b001}, ctrl1_s'{MODE_CMP, fn, ini, inv, 1'b0, 1'b1});
      repeat (3) @(posedge core_clk_i);
      chk1(pin0, ini ^ inv, "initial pin level");
      u_std_timer_pins.pulse(3);
      repeat (4) @(posedge core_clk_i);
      chk1(pin0, e ^ inv, "pin after A match");
      chk1(pin1, e ^ inv, "second pin");
      chk1(af, 1'b1, "A flag");
      chk1(pf, 1'b0, "P flag with clear on A");
      rd_cnt;
      chk32({22'h0, c}, 32'h0, "clear on A match");
    end
  endtask

  // P code 001 on the system clock clears every 128 counts.
  task automatic t_period;
    int n;
    cfg(ctrl0_s'{1'b0, CK_SYS, 1'b1, 3'b001}, ctrl1_s'{MODE_CMP, 2'b00, 1'b0, 1'b0, 1'b0, 1'b0});
    n = 0;
    while (pf !== 1'b1 && n < 300) begin
      @(posedge core_clk_i);
      n++;
    end
    chk1(n >= 120 && n <= 136, 1'b1, "P match time");
    chk1(af, 1'b1, "A flag with clear on P");
    rd_cnt;
    chk1(c < 10'd128, 1'b1, "clear on P match");
  endtask

  // Counts high samples of the pin over len cycles, starting eight cycles after configuring.
  task automatic pwm_hi(input ctrl0_s c0, input ctrl1_s c1, input int len, output int hi);
    cfg(c0, c1);
    repeat (8) @(posedge core_clk_i);
    hi = 0;
    repeat (len) begin
      @(posedge core_clk_i);
      if (pin0 === 1'b1) hi++;
    end
  endtask

  // Active-high PWM on the system clock; period and duty follow the swap bit.
  task automatic t_pwm;
    int hi;
    bus(OFF_CMPA_LO, 1'b1, 32'h40);
    bus(OFF_CMPA_HI, 1'b1, 32'h0);
    pwm_hi(ctrl0_s'{1'b0, CK_SYS, 1'b1, 3'b001},
           ctrl1_s'{MODE_PWM, 2'b10, 1'b1, 1'b0, 1'b0, 1'b0}, 256, hi);
    chk32(hi, 32'd128, "duty 64 of period 128");
    bus(OFF_CMPA_LO, 1'b1, 32'hc8);
    pwm_hi(ctrl0_s'{1'b0, CK_SYS, 1'b1, 3'b001},
           ctrl1_s'{MODE_PWM, 2'b10, 1'b1, 1'b0, 1'b1, 1'b0}, 400, hi);
    chk32(hi, 32'd256, "duty 128 of period 200");
    bus(OFF_CMPA_LO, 1'b1, 32'hff);
    bus(OFF_CMPA_HI, 1'b1, 32'h3);
    pwm_hi(ctrl0_s'{1'b0, CK_SYS, 1'b1, 3'b001},
           ctrl1_s'{MODE_PWM, 2'b10, 1'b1, 1'b0, 1'b0, 1'b0}, 256, hi);
    chk32(hi, 32'd256, "duty above period not full");
    pwm_hi(ctrl0_s'{1'b0, CK_SYS, 1'b1, 3'b001},
           ctrl1_s'{MODE_PWM, 2'b00, 1'b1, 1'b1, 1'b0, 1'b0}, 64, hi);
    chk32(hi, 32'd64, "inverted inactive level");
  endtask

  // Capture: the disabled code ignores an edge, the falling code takes one.
  task automatic t_cap;
    logic [9:0] held;
    cfg(ctrl0_s'{1'b0, CK_SYS, 1'b1, 3'b000},
        ctrl1_s'{MODE_CAP, 2'b11, 1'b0, 1'b0, 1'b0, 1'b0});
    u_std_timer_pins.cap_to(1'b1);
    chk1(af, 1'b0, "capture while disabled");
    cfg(ctrl0_s'{1'b0, CK_SYS, 1'b1, 3'b000},
        ctrl1_s'{MODE_CAP, 2'b01, 1'b0, 1'b0, 1'b0, 1'b0});
    u_std_timer_pins.cap_to(1'b0);
    chk1(af, 1'b1, "capture on falling edge");
    rd_cnt;
    held = c;
    repeat (20) @(posedge core_clk_i);
    rd_cnt;
    chk32({22'h0, c}, {22'h0, held}, "captured count moved");
  endtask

  initial begin
    err_count = 0;
    n_checks  = 0;
    hs_tick   = 1'b0;
    tb_tick   = 1'b0;
    srst_i    = 1'b1;
    hsel      = 1'b0;
    haddr     = 8'h00;
    htrans    = 2'b00;
    hwrite    = 1'b0;
    hsize     = 3'b010;
    hwdata    = 32'h0;
    repeat (8) @(posedge core_clk_i);
    srst_i <= 1'b0;
    @(posedge core_clk_i);
    t_reset;
    t_ext;
    t_cmp;
    t_period;
    t_pwm;
    t_cap;
    final_report;
  end
endmodule // std_timer_core_test
`default_nettype wire

// ### tb/std_timer_pins.sv
// Partner model of the external count pin and the capture pin.
// Assumes the bench calls pulse right after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module std_timer_pins (
  // Clock and pins.
  input  wire logic clk_i,
  output logic      ext_count_o,
  output logic      capture_o
);
  // Both pins idle low.
  initial begin
    ext_count_o = 1'b0;
    capture_o   = 1'b0;
  end

  // Whole pulses, three cycles per level, so a two-flop synchroniser sees each edge.
  task automatic pulse(input int n);
    repeat (n) begin
      ext_count_o <= 1'b1;
      repeat (3) @(posedge clk_i);
      ext_count_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask

  // Moves the capture pin, then lets the synchroniser and flag stages settle.
  task automatic cap_to(input logic v);
    capture_o <= v;
    repeat (6) @(posedge clk_i);
  endtask
endmodule // std_timer_pins
`default_nettype wire

// ### verilog/std_timer_core.sv
// Standard 10-bit timer core with AHB-Lite register slave.
// Assumes single clock core_clk_i, synchronous active-high reset, and that
// high_speed_tick_i and timebase_tick_i are one-cycle enables in that domain.
//
// The AHB-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE1: Ten-bit up-counter on selected clock source.
// RULE2: P compares bits 9-7, A all bits.
// RULE3: Only counter_on rise or a hardware clear clears the counter.
// RULE4: Overflow or selected match clears, raising flags.
// RULE5: Pause holds count; resume from held value.
// RULE6: Clock source select codes; 101 stops counting.
// RULE7: Off holds count; on-rise clears and runs.
// RULE8: Compare mode: on-rise restores initial pin level.
// RULE9: P match in 128-clock steps, 000 means 1024.
// RULE10: P zero, clear-select zero: overflow clears.
// RULE11: Mode select: compare, capture, PWM, timer.
// RULE12: Software stops timer before changing mode.
// RULE13: A match: none, low, high, toggle.
// RULE14: PWM pin: inactive, active, PWM, single pulse.
// RULE15: Capture trigger: rise, fall, both, disabled.
// RULE16: Software changes pin function only while off.
// RULE17: Initial level or active polarity; unused in timer.
// RULE18: Invert pin output; ignored in timer mode.
// RULE19: Swap selects which compare is period.
// RULE20: Clear-select chooses A or P/overflow clear.
// RULE21: Count readable; compare A writable; zero reset.
// RULE22: Clear on A: P flag never raised; the code still raises it in PWM mode when swap makes A the period.
// RULE23: Only A match changes pin in compare.
// RULE24: Duty at or above period gives full.
// RULE25: Software never programs compare A zero.
// RULE26: Synchronise external count input before use.
module std_timer_core
  import std_timer_pkg::*;
(
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  // AHB-Lite slave.
  input  wire logic        hsel_i,
  input  wire logic [7:0]  haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Internal clock enables and pins.
  input  wire logic        high_speed_tick_i,
  input  wire logic        timebase_tick_i,
  input  wire logic        ext_count_input_i,
  input  wire logic        capture_pin_i,
  output logic             timer_output_zero_o,
  output logic             timer_output_one_o,
  output logic             compare_a_flag_o,
  output logic             compare_p_flag_o
);

  ctrl0_s     ctrl0_q;
  ctrl1_s     ctrl1_q;
  logic [9:0] cmpa_q;
  logic [9:0] count_q;
  logic [9:0] capt_q;
  logic       af_q, pf_q;
  logic       on_dly_q;
  logic       pin_q;
  logic       pulse_done_q;
  logic [5:0] pre_q;
  logic [5:0] hpre_q;
  logic [2:0] ext_sync_q;
  logic [1:0] cap_sync_q;
  logic       cap_dly_q;
  logic       wr_pend_q;
  logic [7:0] wr_addr_q;

  // Byte address check used by the write and status-clear paths.
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // AHB address phase capture; the slave is always ready and always OKAY.
  wire logic acc = hsel_i && htrans_i[1] && hready_i;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= acc && hwrite_i;
      wr_addr_q <= haddr_i;
    end
  end

  wire logic on_rise = ctrl0_q.on && !on_dly_q;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) on_dly_q <= 1'b0;
    else on_dly_q <= ctrl0_q.on;
  end

  // Control and compare registers.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ctrl0_q <= ctrl0_s'(CTRL0_RST); // RULE21
      ctrl1_q <= ctrl1_s'(CTRL1_RST);
      cmpa_q  <= CMPA_RST;
    end else if (wr_pend_q) begin
      if (hit(wr_addr_q, OFF_CTRL0)) ctrl0_q <= ctrl0_s'(hwdata_i[7:0]);
      if (hit(wr_addr_q, OFF_CTRL1)) ctrl1_q <= ctrl1_s'(hwdata_i[7:0]);
      if (hit(wr_addr_q, OFF_CMPA_LO)) cmpa_q[7:0] <= hwdata_i[7:0]; // RULE21
      if (hit(wr_addr_q, OFF_CMPA_HI)) cmpa_q[9:8] <= hwdata_i[1:0];
    end
  end

  // Prescalers for divided system and high-speed clocks.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pre_q  <= 6'h00;
      hpre_q <= 6'h00;
    end else begin
      pre_q <= pre_q + 6'h01;
      if (high_speed_tick_i) hpre_q <= hpre_q + 6'h01;
    end
  end

  // External pin: two-flop synchroniser plus one edge stage.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) ext_sync_q <= 3'h0;
    else ext_sync_q <= {ext_sync_q[1:0], ext_count_input_i}; // RULE26
  end

  // Count enable per selected source.
  logic tick;
  always_comb begin
    unique case (ctrl0_q.clk_sel) // RULE6
      CK_SYS4:  tick = pre_q[1:0] == 2'(DIV_SYS4 - 1);
      CK_SYS:   tick = 1'b1;
      CK_HI16:  tick = high_speed_tick_i && hpre_q[3:0] == 4'(DIV_HI16 - 1);
      CK_HI64:  tick = high_speed_tick_i && hpre_q == 6'(DIV_HI64 - 1);
      CK_TBC:   tick = timebase_tick_i;
      CK_STOP:  tick = 1'b0;
      CK_EXT_R: tick = ext_sync_q[1] && !ext_sync_q[2]; // RULE26
      CK_EXT_F: tick = !ext_sync_q[1] && ext_sync_q[2];
    endcase
  end

  wire logic run = ctrl0_q.on && !ctrl0_q.pause && tick; // RULE5 RULE7

  // Comparators and PWM role selection.
  wire logic [9:0] next_cnt = count_q + 10'h001;
  wire logic p_match = next_cnt[9:7] == ctrl0_q.cmp_p && next_cnt[6:0] == 7'h00; // RULE2 RULE9
  wire logic a_match = next_cnt == cmpa_q; // RULE2
  wire logic ovf     = count_q == 10'h3ff;
  wire logic pwm_m   = ctrl1_q.mode == MODE_PWM;
  wire logic cap_m   = ctrl1_q.mode == MODE_CAP;
  wire logic clr_a   = pwm_m ? ctrl1_q.swap : (!cap_m && ctrl1_q.clr_sel); // RULE19 RULE20
  wire logic period_end = clr_a ? a_match : (p_match || ovf); // RULE4 RULE10
  wire logic [10:0] p_len = {(ctrl0_q.cmp_p == 3'h0), ctrl0_q.cmp_p, 7'h00};
  wire logic [10:0] duty  = ctrl1_q.swap ? p_len : {1'b0, cmpa_q};
  wire logic [10:0] per   = ctrl1_q.swap ? {1'b0, cmpa_q} : p_len;
  wire logic pwm_lvl = (duty >= per) || ({1'b0, count_q} < duty); // RULE24
  wire logic set_pf  = run && p_match && !(clr_a && !pwm_m); // RULE22
  wire logic set_af  = run && a_match && cmpa_q != 10'h000;

  // Counter: cleared only by on-rise or by hardware.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) count_q <= 10'h000;
    else if (on_rise) count_q <= 10'h000; // RULE3 RULE7
    else if (run && period_end) count_q <= 10'h000; // RULE4
    else if (run) count_q <= next_cnt; // RULE1
  end

  // Capture input edge detection.
  logic cap_ev;
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cap_sync_q <= 2'h0;
      cap_dly_q  <= 1'b0;
      capt_q     <= 10'h000;
    end else begin
      cap_sync_q <= {cap_sync_q[0], capture_pin_i};
      cap_dly_q  <= cap_sync_q[1];
      if (cap_m && ctrl0_q.on && cap_ev) capt_q <= count_q;
    end
  end
  wire logic cap_r = cap_sync_q[1] && !cap_dly_q;
  wire logic cap_f = !cap_sync_q[1] && cap_dly_q;
  always_comb begin
    unique case (ctrl1_q.pin_fn) // RULE15
      2'b00: cap_ev = cap_r;
      2'b01: cap_ev = cap_f;
      2'b10: cap_ev = cap_r || cap_f;
      2'b11: cap_ev = 1'b0;
    endcase
  end

  wire logic clr_stat = wr_pend_q && hit(wr_addr_q, OFF_STATUS);
  // Sticky flags: a set in the same cycle as a clear wins.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      af_q <= 1'b0;
      pf_q <= 1'b0;
    end else begin
      af_q <= (set_af || (cap_m && ctrl0_q.on && cap_ev)) ||
              (af_q && !(clr_stat && hwdata_i[STAT_AF]));
      pf_q <= set_pf || (pf_q && !(clr_stat && hwdata_i[STAT_PF])); // RULE22
    end
  end

  // Pin state: compare-mode level or single-pulse state.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      pin_q        <= 1'b0;
      pulse_done_q <= 1'b0;
    end else if (on_rise) begin
      pin_q        <= ctrl1_q.init_lvl; // RULE8 RULE17
      pulse_done_q <= 1'b0;
    end else if (ctrl1_q.mode == MODE_CMP && set_af) begin
      unique case (ctrl1_q.pin_fn) // RULE13 RULE23
        2'b00: pin_q <= pin_q;
        2'b01: pin_q <= 1'b0;
        2'b10: pin_q <= 1'b1;
        2'b11: pin_q <= !pin_q;
      endcase
    end else if (pwm_m && run && period_end) begin
      pulse_done_q <= 1'b1;
    end
  end

  // Output level per mode, then polarity inversion.
  logic raw;
  always_comb begin
    raw = 1'b0;
    unique case (ctrl1_q.mode) // RULE11
      MODE_CMP: raw = pin_q;
      MODE_PWM: begin
        unique case (ctrl1_q.pin_fn) // RULE14
          2'b00: raw = !ctrl1_q.init_lvl;
          2'b01: raw = ctrl1_q.init_lvl;
          2'b10: raw = (pwm_lvl && ctrl0_q.on) ~^ ctrl1_q.init_lvl; // RULE17
          2'b11: raw = (!pulse_done_q && ctrl0_q.on) ~^ ctrl1_q.init_lvl;
        endcase
      end
      MODE_CAP: raw = 1'b0;
      MODE_TMR: raw = 1'b0;
    endcase
  end
  wire logic use_pin = ctrl1_q.mode != MODE_TMR;
  wire logic out_d = use_pin && (raw ^ ctrl1_q.invert); // RULE18

  // Registered outputs.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      timer_output_zero_o <= 1'b0;
      timer_output_one_o  <= 1'b0;
      compare_a_flag_o    <= 1'b0;
      compare_p_flag_o    <= 1'b0;
    end else begin
      timer_output_zero_o <= out_d;
      timer_output_one_o  <= out_d;
      compare_a_flag_o    <= af_q;
      compare_p_flag_o    <= pf_q;
    end
  end

  // Read data in the cycle after the address phase; unmapped reads zero.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (acc && !hwrite_i) begin
        unique case (haddr_i)
          OFF_CTRL0:   hrdata_o <= {24'h0, ctrl0_q};
          OFF_CTRL1:   hrdata_o <= {24'h0, ctrl1_q};
          OFF_CNT_LO:  hrdata_o <= {24'h0, (cap_m ? capt_q[7:0] : count_q[7:0])}; // RULE21
          OFF_CNT_HI:  hrdata_o <= {30'h0, (cap_m ? capt_q[9:8] : count_q[9:8])};
          OFF_CMPA_LO: hrdata_o <= {24'h0, cmpa_q[7:0]};
          OFF_CMPA_HI: hrdata_o <= {30'h0, cmpa_q[9:8]};
          OFF_STATUS:  hrdata_o <= {30'h0, pf_q, af_q};
          default:     hrdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Assertions.
  cnt_on_clear_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    on_rise |=> count_q == 10'h000) else $error("count not cleared on enable"); // RULE7
  pause_hold_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ctrl0_q.pause && !on_rise) |=> $stable(count_q)) else $error("count moved in pause"); // RULE5
  off_hold_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (!ctrl0_q.on && !on_rise) |=> $stable(count_q)) else $error("count moved while off"); // RULE7
  stop_src_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ctrl0_q.clk_sel == CK_STOP && !on_rise) |=> $stable(count_q)) else $error("reserved source ran"); // RULE6
  no_pf_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ctrl1_q.mode == MODE_CMP && ctrl1_q.clr_sel && !pf_q) |=> !pf_q) else $error("P flag set"); // RULE22
  init_lvl_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (on_rise && ctrl1_q.mode == MODE_CMP) |=> pin_q == $past(ctrl1_q.init_lvl)) else $error("init lvl"); // RULE8
  tmr_pin_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (ctrl1_q.mode == MODE_TMR) |=> !timer_output_zero_o) else $error("pin driven in timer mode"); // RULE18
  wrap_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (run && !on_rise && count_q == 10'h3ff) |=> count_q == 10'h000) else $error("no overflow clear"); // RULE4
  p_clear_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (run && !on_rise && p_match && !clr_a) |=> count_q == 10'h000 ##0 pf_q) else $error("P clear"); // RULE9
  cv_pf: cover property (@(posedge core_clk_i) set_pf);
  cv_af: cover property (@(posedge core_clk_i) set_af && ctrl1_q.pin_fn == 2'b11);
  cv_pwm: cover property (@(posedge core_clk_i) pwm_m && run && period_end);

endmodule : std_timer_core
`default_nettype wire
